// ===== rtl/rtcit_regs.svh
// named constants of the two-wire real-time-clock target interface
`ifndef RTCIT_REGS_SVH
`define RTCIT_REGS_SVH
`define RTCIT_OWN_ADDR   7'h52
`define RTCIT_BYTE_BITS  4'h8
`define RTCIT_LAST_TX    4'h7
`define RTCIT_PTR_RST    8'h00
`define RTCIT_TOUT_MS    950
`define RTCIT_MCLK_KHZ   40000
`define RTCIT_FIFO_W     16
`define RTCIT_FIFO_D     16
`define RTCIT_FIFO_AW    4
`endif

// ===== rtl/rtcit_pkg.sv
// types shared by the two-wire real-time-clock target interface
package rtcit_pkg;
	typedef logic [7:0] rtcit_byte_t;
	typedef enum logic [2:0]
	{
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR       = 3'b011,
		ST_WR_ACK   = 3'b100,
		ST_RD       = 3'b101,
		ST_RD_ACK   = 3'b110
	} rtcit_state_t;
endpackage

// ===== rtl/rtcit_top.sv
// two-wire target interface with pointer, timeout, backup disable and write fifo
`timescale 1ns/100ps
`include "rtcit_regs.svh"

module rtcit_fifo #(
	parameter int W  = `RTCIT_FIFO_W,
	parameter int D  = `RTCIT_FIFO_D,
	parameter int AW = `RTCIT_FIFO_AW
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         s_valid,
	output logic              s_ready,
	input  wire logic [W-1:0] s_data,
	output logic              m_valid,
	input  wire logic         m_ready,
	output logic [W-1:0]      m_data
);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          push, pop, m_valid_nxt;
	logic [W-1:0]  m_data_nxt;

	// head word is registered so m_valid and m_data come from flops
	always_comb
	begin
		s_ready     = cnt_r != (AW+1)'(D);
		push        = s_valid & s_ready;
		pop         = m_valid & m_ready;
		wp_nxt      = wp_r + AW'(push);
		rp_nxt      = rp_r + AW'(pop);
		cnt_nxt     = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		m_valid_nxt = cnt_nxt != '0;
		m_data_nxt  = (push && wp_r == rp_nxt) ? s_data : mem[rp_nxt];
	end

	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wp_r] <= s_data;
		if (rst)
		begin
			wp_r    <= '0;
			rp_r    <= '0;
			cnt_r   <= '0;
			m_valid <= 1'b0;
			m_data  <= '0;
		end
		else
		begin
			wp_r    <= wp_nxt;
			rp_r    <= rp_nxt;
			cnt_r   <= cnt_nxt;
			m_valid <= m_valid_nxt;
			m_data  <= m_data_nxt;
		end
	end
endmodule

module rtcit_top #(
	parameter int unsigned TOUT_CYC = `RTCIT_TOUT_MS * `RTCIT_MCLK_KHZ
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 scl,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	input  wire logic                 backup_supply_state,
	output rtcit_pkg::rtcit_byte_t    rd_addr,
	input  wire rtcit_pkg::rtcit_byte_t rd_data,
	output logic                      wr_valid,
	input  wire logic                 wr_ready,
	output rtcit_pkg::rtcit_byte_t    wr_addr,
	output rtcit_pkg::rtcit_byte_t    wr_data
);
	import rtcit_pkg::*;

	logic [2:0]   scl_s_r, sda_s_r, bk_s_r;
	logic         scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt, bk_f_r, bk_f_nxt;
	logic         scl_p_r, sda_p_r;
	logic         ev_start, ev_stop, scl_rise, scl_fall, tmo_hit, fifo_rdy, push_c;
	rtcit_state_t state_r, state_nxt;
	logic [3:0]   cnt_r, cnt_nxt;
	rtcit_byte_t  sh_r, sh_nxt, ptr_r, ptr_nxt;
	logic         oe_r, oe_nxt, rw_r, rw_nxt, first_r, first_nxt, mack_r, mack_nxt;
	logic         busy_r, busy_nxt, tmo_r, tmo_nxt;
	logic [25:0]  tcnt_r, tcnt_nxt;
	logic [15:0]  fifo_q;

	// a level counts once the second and third stages agree
	always_comb
	begin
		scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
		sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
		bk_f_nxt  = (bk_s_r[1] == bk_s_r[2]) ? bk_s_r[2] : bk_f_r;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			bk_s_r  <= 3'h0;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			bk_f_r  <= 1'b0;
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end
		else
		begin
			scl_s_r <= {scl_s_r[1:0], scl};
			sda_s_r <= {sda_s_r[1:0], sda_in};
			bk_s_r  <= {bk_s_r[1:0], backup_supply_state};
			scl_f_r <= scl_f_nxt;
			sda_f_r <= sda_f_nxt;
			bk_f_r  <= bk_f_nxt;
			scl_p_r <= scl_f_r;
			sda_p_r <= sda_f_r;
		end
	end

	assign ev_start = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
	assign ev_stop  = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;
	assign scl_rise = scl_f_r & ~scl_p_r;
	assign scl_fall = ~scl_f_r & scl_p_r;
	assign tmo_hit  = busy_r && tcnt_r == 26'(TOUT_CYC - 1);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		ptr_nxt   = ptr_r;
		oe_nxt    = oe_r;
		rw_nxt    = rw_r;
		first_nxt = first_r;
		mack_nxt  = mack_r;
		busy_nxt  = busy_r;
		tmo_nxt   = tmo_r;
		tcnt_nxt  = busy_r ? tcnt_r + 26'h0000001 : 26'h0000000;
		push_c    = 1'b0;
		if (bk_f_r)
		begin
			state_nxt = ST_IDLE;
			oe_nxt    = 1'b0;
			cnt_nxt   = 4'h0;
			ptr_nxt   = `RTCIT_PTR_RST;
			busy_nxt  = 1'b0;
			tmo_nxt   = 1'b0;
			tcnt_nxt  = 26'h0000000;
		end
		else if (tmo_hit)
		begin
			// idle ignores traffic until a start; released data reads as FFh
			state_nxt = ST_IDLE;
			oe_nxt    = 1'b0;
			busy_nxt  = 1'b0;
			tmo_nxt   = 1'b1;
		end
		else if (ev_start)
		begin
			state_nxt = ST_ADDR;
			cnt_nxt   = 4'h0;
			oe_nxt    = 1'b0;
			busy_nxt  = 1'b1;
			tcnt_nxt  = 26'h0000000;
			tmo_nxt   = 1'b0;
		end
		else if (ev_stop)
		begin
			state_nxt = ST_IDLE;
			oe_nxt    = 1'b0;
			busy_nxt  = 1'b0;
		end
		else
		begin
			case (state_r)
				ST_ADDR, ST_WR:
				begin
					if (scl_rise && cnt_r != `RTCIT_BYTE_BITS)
					begin
						sh_nxt  = {sh_r[6:0], sda_f_r};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (scl_fall && cnt_r == `RTCIT_BYTE_BITS && state_r == ST_ADDR)
					begin
						rw_nxt = sh_r[0];
						if (sh_r[7:1] == `RTCIT_OWN_ADDR)
						begin
							state_nxt = ST_ADDR_ACK;
							oe_nxt    = 1'b1;
						end
						else
							state_nxt = ST_IDLE;
					end
					else if (scl_fall && cnt_r == `RTCIT_BYTE_BITS)
					begin
						// a full fifo refuses the byte since the clock may not be stretched
						if (first_r)
						begin
							ptr_nxt   = sh_r;
							first_nxt = 1'b0;
							state_nxt = ST_WR_ACK;
							oe_nxt    = 1'b1;
						end
						else if (fifo_rdy)
						begin
							push_c    = 1'b1;
							ptr_nxt   = ptr_r + 8'h01;
							state_nxt = ST_WR_ACK;
							oe_nxt    = 1'b1;
						end
						else
							state_nxt = ST_IDLE;
					end
				end
				ST_ADDR_ACK, ST_WR_ACK:
				begin
					if (scl_fall)
					begin
						cnt_nxt = 4'h0;
						if (state_r == ST_ADDR_ACK && rw_r)
						begin
							sh_nxt    = rd_data;
							oe_nxt    = ~rd_data[7];
							state_nxt = ST_RD;
						end
						else
						begin
							first_nxt = state_r == ST_ADDR_ACK ? 1'b1 : first_r;
							oe_nxt    = 1'b0;
							state_nxt = ST_WR;
						end
					end
				end
				ST_RD:
				begin
					if (scl_fall)
					begin
						if (cnt_r == `RTCIT_LAST_TX)
						begin
							oe_nxt    = 1'b0;
							state_nxt = ST_RD_ACK;
							ptr_nxt   = ptr_r + 8'h01;
						end
						else
						begin
							sh_nxt  = {sh_r[6:0], 1'b0};
							oe_nxt  = ~sh_r[6];
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				end
				ST_RD_ACK:
				begin
					if (scl_rise)
						mack_nxt = ~sda_f_r;
					else if (scl_fall && mack_r)
					begin
						sh_nxt    = rd_data;
						oe_nxt    = ~rd_data[7];
						cnt_nxt   = 4'h0;
						state_nxt = ST_RD;
					end
					else if (scl_fall)
					begin
						oe_nxt    = 1'b0;
						state_nxt = ST_IDLE;
					end
				end
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			ptr_r   <= `RTCIT_PTR_RST;
			oe_r    <= 1'b0;
			rw_r    <= 1'b0;
			first_r <= 1'b0;
			mack_r  <= 1'b0;
			busy_r  <= 1'b0;
			tmo_r   <= 1'b0;
			tcnt_r  <= 26'h0000000;
			sda_out <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= ptr_nxt;
			oe_r    <= oe_nxt;
			rw_r    <= rw_nxt;
			first_r <= first_nxt;
			mack_r  <= mack_nxt;
			busy_r  <= busy_nxt;
			tmo_r   <= tmo_nxt;
			tcnt_r  <= tcnt_nxt;
			sda_out <= 1'b0;
		end
	end

	assign sda_oe  = oe_r;
	assign rd_addr = ptr_r;

	rtcit_fifo #(.W(`RTCIT_FIFO_W), .D(`RTCIT_FIFO_D), .AW(`RTCIT_FIFO_AW)) u_fifo
	(
		.mclk    (mclk),
		.rst     (rst),
		.s_valid (push_c),
		.s_ready (fifo_rdy),
		.s_data  ({ptr_r, sh_r}),
		.m_valid (wr_valid),
		.m_ready (wr_ready),
		.m_data  (fifo_q)
	);
	assign wr_addr = fifo_q[15:8];
	assign wr_data = fifo_q[7:0];

	a_start_to_addr: assert property (@(posedge mclk) disable iff (rst)
		ev_start && !bk_f_r && !tmo_hit |=> state_r == ST_ADDR && cnt_r == 4'h0)
		else $error("start not taken");
	a_stop_to_idle: assert property (@(posedge mclk) disable iff (rst)
		ev_stop && !ev_start |=> state_r == ST_IDLE && !busy_r && !sda_oe)
		else $error("stop did not end transfer");
	a_restart_fresh: assert property (@(posedge mclk) disable iff (rst)
		ev_start && !bk_f_r && !tmo_hit && state_r != ST_IDLE |=> state_r == ST_ADDR && tcnt_r == 26'h0000000)
		else $error("repeated start not fresh");
	a_timeout_clear: assert property (@(posedge mclk) disable iff (rst)
		tmo_hit && !bk_f_r |=> state_r == ST_IDLE && tmo_r && !busy_r)
		else $error("timeout did not clear");
	a_timeout_quiet: assert property (@(posedge mclk) disable iff (rst)
		tmo_r |-> !sda_oe && !push_c)
		else $error("activity after timeout");
	a_own_addr_ack: assert property (@(posedge mclk) disable iff (rst)
		state_r == ST_ADDR && scl_fall && cnt_r == `RTCIT_BYTE_BITS && sh_r[7:1] == `RTCIT_OWN_ADDR
		&& !ev_start && !ev_stop && !tmo_hit && !bk_f_r |=> sda_oe && state_r == ST_ADDR_ACK)
		else $error("own address not acked");
	a_foreign_nack: assert property (@(posedge mclk) disable iff (rst)
		state_r == ST_ADDR && scl_fall && cnt_r == `RTCIT_BYTE_BITS && sh_r[7:1] != `RTCIT_OWN_ADDR
		|=> !sda_oe && state_r == ST_IDLE)
		else $error("foreign address acked");
	a_ptr_load: assert property (@(posedge mclk) disable iff (rst)
		state_r == ST_WR && first_r && scl_fall && cnt_r == `RTCIT_BYTE_BITS
		&& !ev_start && !ev_stop && !tmo_hit && !bk_f_r |=> ptr_r == $past(sh_r) && sda_oe)
		else $error("pointer not loaded");
	a_nack_release: assert property (@(posedge mclk) disable iff (rst)
		state_r == ST_RD_ACK && scl_fall && !mack_r |=> !sda_oe [*2])
		else $error("data not released after nack");
	a_backup_reset: assert property (@(posedge mclk) disable iff (rst)
		bk_f_r |=> !sda_oe && state_r == ST_IDLE && ptr_r == `RTCIT_PTR_RST)
		else $error("backup did not reset interface");
endmodule

// ===== dv/rtcit_bus_ctrl.sv
// two-wire bus controller model that drives the clock and pulls the data line
`timescale 1ns/100ps
module rtcit_bus_ctrl #(
	parameter int QTR = 8
) (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// quarter bit; clock phases stay well above the target's sampling needs
	task automatic q();
		repeat (QTR) @(posedge mclk);
	endtask
	// start, or repeated start when the clock is already low
	task automatic start();
		if (scl === 1'b0)
		begin
			sda_low <= 1'b0;
			q();
			scl <= 1'b1;
			q();
		end
		sda_low <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask
	// clock stands still high after a stop
	task automatic stop();
		sda_low <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_low <= 1'b0;
		q();
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		q();
		scl <= 1'b1;
		q();
		r = sda;
		q();
		scl <= 1'b0;
		q();
	endtask
	// eight bits msb first, then the acknowledge clock
	task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] rd, output logic r9);
		for (int i = 7; i >= 0; i--) bit_io(d[i], rd[i]);
		bit_io(b9, r9);
	endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the two-wire target interface
`timescale 1ns/100ps
module tb_top;
	import rtcit_pkg::*;
	localparam int TOUT = 8000;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        backup = 1'b0;
	logic        wr_ready = 1'b0;
	logic        scl, sda_low, sda_out, sda_oe, wr_valid, ack;
	rtcit_byte_t rd_addr, rd_data, wr_addr, wr_data, rx;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc = 0;
	// open-drain data line with pull-up
	wire         sda = ~(sda_low | (sda_oe & ~sda_out));
	assign rd_data = rd_addr ^ 8'hA6;
	rtcit_top #(.TOUT_CYC(TOUT)) rtcit_top_inst (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .backup_supply_state(backup), .rd_addr(rd_addr),
		.rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
	rtcit_bus_ctrl #(.QTR(8)) m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			final_report();
		end
	end
	task automatic final_report();
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wb(input rtcit_byte_t d, input logic ea, input string n);
		m.xfer(d, 1'b1, rx, ack);
		chk(n, {7'h00, ea}, {7'h00, ~ack});
	endtask
	task automatic rb(input logic last, input rtcit_byte_t e);
		m.xfer(8'hFF, last, rx, ack);
		chk("read byte", e, rx);
	endtask
	// consumer stalls between pops
	task automatic pop(input rtcit_byte_t ea, input rtcit_byte_t ed);
		int n;
		n = 0;
		while (wr_valid !== 1'b1 && n < 50)
		begin
			@(posedge mclk);
			n++;
		end
		chk("fifo addr", ea, wr_addr);
		chk("fifo data", ed, wr_data);
		wr_ready <= 1'b1;
		@(posedge mclk);
		wr_ready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic t_fill();
		m.start();
		wb(8'hA4, 1'b1, "write addr ack");
		wb(8'h10, 1'b1, "pointer ack");
		chk("pointer", 8'h10, rd_addr);
		for (int i = 0; i < 16; i++) wb(8'h30 + i[7:0], 1'b1, "data ack");
		wb(8'h77, 1'b0, "full fifo nack");
		chk("pointer after fill", 8'h20, rd_addr);
		m.stop();
		for (int i = 0; i < 16; i++) pop(8'h10 + i[7:0], 8'h30 + i[7:0]);
		chk("fifo empty", 8'h00, {7'h00, wr_valid});
	endtask
	// pointer chosen so the byte after the nack would pull data low if not released
	task automatic t_read();
		m.start();
		wb(8'hA4, 1'b1, "write addr ack");
		wb(8'hC0, 1'b1, "pointer ack");
		m.start();
		wb(8'hA5, 1'b1, "read addr ack");
		rb(1'b0, 8'hC0 ^ 8'hA6);
		rb(1'b0, 8'hC1 ^ 8'hA6);
		rb(1'b1, 8'hC2 ^ 8'hA6);
		chk("release after nack", 8'h00, {7'h00, sda_oe});
		m.stop();
		m.start();
		wb(8'hA5, 1'b1, "read addr ack");
		rb(1'b1, 8'hC3 ^ 8'hA6);
		m.stop();
	endtask
	task automatic t_foreign();
		m.start();
		wb(8'hA6, 1'b0, "foreign addr nack");
		wb(8'h12, 1'b0, "ignored byte nack");
		m.stop();
		chk("no push", 8'h00, {7'h00, wr_valid});
		chk("pointer kept", 8'hC4, rd_addr);
	endtask
	// transaction held open past the limit on purpose; target drives a low bit while waiting
	task automatic t_timeout();
		m.start();
		wb(8'hA5, 1'b1, "read addr ack");
		repeat (TOUT + 50) @(posedge mclk);
		rb(1'b0, 8'hFF);
		wb(8'h55, 1'b0, "write after clear nack");
		m.stop();
		chk("no push after clear", 8'h00, {7'h00, wr_valid});
		m.start();
		wb(8'hA4, 1'b1, "ack after new start");
		m.stop();
	endtask
	// backup arrives while the target is pulling data low for a read bit
	task automatic t_backup();
		m.start();
		wb(8'hA4, 1'b1, "write addr ack");
		wb(8'h88, 1'b1, "pointer ack");
		m.start();
		wb(8'hA5, 1'b1, "read addr ack");
		chk("oe before backup", 8'h01, {7'h00, sda_oe});
		backup <= 1'b1;
		repeat (10) @(posedge mclk);
		chk("oe in backup", 8'h00, {7'h00, sda_oe});
		chk("pointer in backup", 8'h00, rd_addr);
		wb(8'h99, 1'b0, "nack in backup");
		backup <= 1'b0;
		repeat (10) @(posedge mclk);
		m.stop();
		m.start();
		wb(8'hA4, 1'b1, "ack after backup");
		m.stop();
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		chk("reset pointer", 8'h00, rd_addr);
		t_fill();
		t_read();
		t_foreign();
		t_timeout();
		t_backup();
		final_report();
	end
endmodule
